// ==== verilog/uart_status_flags.sv ====
// Status-flag logic of an asynchronous serial port, with its control,
// baud and shared data registers and a two-word receive buffer.
// Assumes shift engines on the same clock report receive and transmit
// events as one-cycle pulses and levels; no synchronisers are needed.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns

module uart_status_flags (
  input  wire logic                                clock,
  input  wire logic                                rst,
  // Register port
  input  wire logic [uart_flags_pkg::ADDR_W-1:0]   addr,
  input  wire logic [uart_flags_pkg::DATA_W-1:0]   wdata,
  input  wire logic                                wr_stb,
  input  wire logic                                rd_stb,
  output logic      [uart_flags_pkg::DATA_W-1:0]   rdata,
  // Receive shift engine
  input  wire logic                                rx_start_seen,
  input  wire logic                                rx_stop_done,
  input  wire logic                                rx_word_done,
  input  wire logic [uart_flags_pkg::DATA_W-1:0]   rx_word,
  input  wire logic                                rx_noise,
  input  wire logic                                rx_framing_bad,
  input  wire logic                                rx_parity_bad,
  // Transmit shift engine, serial line and receive interrupt
  input  wire logic                                tx_shift_free,
  input  wire logic                                tx_shift_busy,
  input  wire logic                                tx_serial,
  output logic                                     tx_load,
  output logic      [uart_flags_pkg::DATA_W-1:0]   tx_word,
  output logic                                     tx_pin,
  output logic                                     receive_irq,
  // Configuration to the engines and baud generator
  output logic      [uart_flags_pkg::DATA_W-1:0]   control_one,
  output logic      [uart_flags_pkg::DATA_W-1:0]   control_two,
  output logic      [uart_flags_pkg::DATA_W-1:0]   baud_divisor
);
  import uart_flags_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [ERR_COUNT-1:0] err_r;
  logic                 rx_idle_r;
  logic                 rx_full_r;
  logic                 tx_idle_r;
  logic                 tx_empty_r;
  logic [DATA_W-1:0]    armed_r;
  logic [DATA_W-1:0]    status;

  logic [DATA_W-1:0]    rx_buf_r [RX_DEPTH];
  logic [1:0]           rx_count_r;
  logic [DATA_W-1:0]    tx_hold_r;
  logic                 tx_hold_valid_r;

  logic port_en;
  logic rx_en;
  logic tx_en;
  logic st_rd;
  logic data_rd;
  logic data_wr;
  logic data_access;
  logic pop;
  logic push;
  logic overrun_hit;
  logic move_to_shifter;
  logic tx_enable_rise;
  logic break_active;
  logic [1:0] rx_count_after_pop;
  logic [ERR_COUNT-1:0] err_set;

  assign port_en     = control_one[C1_PORT_EN];
  assign rx_en       = port_en & control_two[C2_RX_EN];
  assign tx_en       = port_en & control_two[C2_TX_EN];
  assign st_rd       = rd_stb & hit(addr, OFS_STATUS);
  assign data_rd     = rd_stb & hit(addr, OFS_DATA);
  assign data_wr     = wr_stb & hit(addr, OFS_DATA);
  assign data_access = data_rd | data_wr;
  assign break_active = tx_en & control_one[C1_SEND_BREAK];

  assign status = {err_r[ERR_PARITY], err_r[ERR_NOISE],
                   err_r[ERR_FRAMING], err_r[ERR_OVERRUN],
                   rx_idle_r, rx_full_r, tx_idle_r, tx_empty_r};

  // Receive buffer control
  assign pop  = data_rd & (rx_count_r != 2'h0);
  assign rx_count_after_pop = pop ? rx_count_r - 2'h1 : rx_count_r;
  // A word arriving with the buffer still full after this cycle's pop,
  // or with overrun already pending, is dropped
  assign overrun_hit = rx_en & rx_word_done &
                       ((rx_count_after_pop == RX_FULL_COUNT) |
                        err_r[ERR_OVERRUN]);
  assign push = rx_en & rx_word_done & ~overrun_hit;

  assign err_set[ERR_OVERRUN] = overrun_hit;
  assign err_set[ERR_FRAMING] = push & rx_framing_bad;
  assign err_set[ERR_NOISE]   = push & rx_noise;
  assign err_set[ERR_PARITY]  = push & rx_parity_bad &
                                control_one[C1_PARITY_EN];

  // Transmit path
  assign move_to_shifter = tx_en & tx_hold_valid_r & tx_shift_free;
  assign tx_enable_rise  = wr_stb & hit(addr, OFS_CTRL2) &
                           wdata[C2_TX_EN] & ~control_two[C2_TX_EN];

  // Control, baud registers; disable clears the transmit and receive enables and break
  always_ff @(posedge clock) begin
    if (rst) begin
      control_one <= CTRL1_RESET;
    end else if (wr_stb && hit(addr, OFS_CTRL1)) begin
      control_one <= wdata[C1_PORT_EN] ? wdata : wdata & ~C1_DISABLE_CLR;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      control_two <= CTRL2_RESET;
    end else if (wr_stb && hit(addr, OFS_CTRL2)) begin
      control_two <= wdata;
    end else if (!port_en) begin
      control_two <= control_two & ~C2_DISABLE_CLR;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      baud_divisor <= BAUD_RESET;
    end else if (wr_stb && hit(addr, OFS_BAUD)) begin
      baud_divisor <= wdata;
    end
  end

  // Register reads; the status register has no write path
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= RDATA_RESET;
    end else if (rd_stb) begin
      unique case (addr)
        OFS_STATUS: rdata <= status;
        OFS_CTRL1:  rdata <= control_one & C1_READ_MASK;
        OFS_CTRL2:  rdata <= control_two;
        OFS_DATA:   rdata <= rx_buf_r[0];
        OFS_BAUD:   rdata <= baud_divisor;
        default:    rdata <= RDATA_RESET;
      endcase
    end
  end

  // Per-flag record of a status read that showed the flag set.
  // Any data access consumes the record, so stale reads cannot clear.
  always_ff @(posedge clock) begin
    if (rst || !port_en) begin
      armed_r <= 8'h00;
    end else if (st_rd) begin
      armed_r <= status;
    end else if (data_access) begin
      armed_r <= 8'h00;
    end
  end

  // Error flags: a set in the clearing cycle wins
  for (genvar i = 0; i < ERR_COUNT; i++) begin : g_err
    always_ff @(posedge clock) begin
      if (rst || !port_en) begin
        err_r[i] <= 1'b0;
      end else if (err_set[i]) begin
        err_r[i] <= 1'b1;
      end else if (data_access && armed_r[ERR_BASE + i]) begin
        err_r[i] <= 1'b0;
      end
    end
  end

  // Two-word receive buffer; head always at entry zero
  always_ff @(posedge clock) begin
    if (rst || !port_en) begin
      rx_count_r <= 2'h0;
    end else begin
      rx_count_r <= rx_count_after_pop + {1'b0, push};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_buf_r[0] <= RDATA_RESET;
      rx_buf_r[1] <= RDATA_RESET;
    end else begin
      if (pop) begin
        rx_buf_r[0] <= rx_buf_r[1];
      end
      if (push) begin
        rx_buf_r[rx_count_after_pop[0]] <= rx_word;
      end
    end
  end

  // Receive full flag
  always_ff @(posedge clock) begin
    if (rst || !port_en) begin
      rx_full_r <= 1'b0;
    end else if (push) begin
      rx_full_r <= 1'b1;
    end else if (data_rd && armed_r[ST_RX_FULL] &&
                 rx_count_after_pop == 2'h0) begin
      rx_full_r <= 1'b0;
    end
  end

  // One-cycle receive interrupt request on each word load
  always_ff @(posedge clock) begin
    if (rst) begin
      receive_irq <= 1'b0;
    end else begin
      receive_irq <= push & control_two[C2_RX_IE];
    end
  end

  // Receiver idle: low from start detection to stop completion
  always_ff @(posedge clock) begin
    if (rst || !rx_en) begin
      rx_idle_r <= 1'b1;
    end else if (rx_start_seen) begin
      rx_idle_r <= 1'b0;
    end else if (rx_stop_done) begin
      rx_idle_r <= 1'b1;
    end
  end

  // Transmit holding register: a data write loads it
  always_ff @(posedge clock) begin
    if (rst || !port_en) begin
      tx_hold_valid_r <= 1'b0;
      tx_hold_r       <= RDATA_RESET;
    end else if (data_wr) begin
      tx_hold_valid_r <= 1'b1;
      tx_hold_r       <= wdata;
    end else if (move_to_shifter) begin
      tx_hold_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_load <= 1'b0;
      tx_word <= RDATA_RESET;
    end else begin
      tx_load <= move_to_shifter & ~data_wr;
      if (move_to_shifter) begin
        tx_word <= tx_hold_r;
      end
    end
  end

  // Transmit empty flag. A write in the move cycle reloads the holding
  // register, so the move is held back by one cycle in that case.
  always_ff @(posedge clock) begin
    if (rst || !port_en) begin
      tx_empty_r <= 1'b1;
    end else if ((move_to_shifter && !data_wr) || tx_enable_rise) begin
      tx_empty_r <= 1'b1;
    end else if (data_wr && armed_r[ST_TX_EMPTY]) begin
      tx_empty_r <= 1'b0;
    end
  end

  // Transmitter idle: nothing held, nothing shifting, no break
  always_ff @(posedge clock) begin
    if (rst || !port_en) begin
      tx_idle_r <= 1'b1;
    end else if (data_wr && armed_r[ST_TX_IDLE]) begin
      tx_idle_r <= 1'b0;
    end else if (tx_hold_valid_r || break_active || tx_shift_busy) begin
      tx_idle_r <= 1'b0;
    end else if (tx_empty_r) begin
      tx_idle_r <= 1'b1;
    end
  end

  // Line driver: high when idle, low for break once shifting ends
  always_ff @(posedge clock) begin
    if (rst || !tx_en) begin
      tx_pin <= 1'b1;
    end else if (tx_idle_r) begin
      tx_pin <= 1'b1;
    end else if (tx_shift_busy) begin
      tx_pin <= tx_serial;
    end else begin
      tx_pin <= ~break_active;
    end
  end

endmodule // uart_status_flags

// ==== shared/uart_flags_pkg.sv ====
// Constants for the serial port status-flag block: offsets, bit fields,
// reset values and buffer size. Shared by design and bench.
package uart_flags_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL1  = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CTRL2  = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_DATA   = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_BAUD   = 3'h4;

  // Status flag positions
  localparam int ST_PARITY   = 7;
  localparam int ST_NOISE    = 6;
  localparam int ST_FRAMING  = 5;
  localparam int ST_OVERRUN  = 4;
  localparam int ST_RX_IDLE  = 3;
  localparam int ST_RX_FULL  = 2;
  localparam int ST_TX_IDLE  = 1;
  localparam int ST_TX_EMPTY = 0;

  // Error flags in the error vector (index = status bit - 4)
  localparam int ERR_OVERRUN = 0;
  localparam int ERR_FRAMING = 1;
  localparam int ERR_NOISE   = 2;
  localparam int ERR_PARITY  = 3;
  localparam int ERR_COUNT   = 4;
  localparam int ERR_BASE    = 4;

  // Control register one fields
  localparam int C1_PORT_EN    = 7;
  localparam int C1_NINE_BIT   = 6;
  localparam int C1_PARITY_EN  = 5;
  localparam int C1_PARITY_ODD = 4;
  localparam int C1_TWO_STOP   = 3;
  localparam int C1_SEND_BREAK = 2;
  localparam int C1_RX_BIT8    = 1;
  localparam int C1_TX_BIT8    = 0;

  // Control register two fields
  localparam int C2_TX_EN   = 7;
  localparam int C2_RX_EN   = 6;
  localparam int C2_RX_IE   = 2;

  // Bits of control one that a port disable clears, and of control two
  localparam logic [DATA_W-1:0] C1_DISABLE_CLR = 8'h04;
  localparam logic [DATA_W-1:0] C2_DISABLE_CLR = 8'hc0;
  // Receive bit 8 and transmit bit 8 both read back as zero
  localparam logic [DATA_W-1:0] C1_READ_MASK  = 8'hfc;

  // Reset values
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h0b;
  localparam logic [DATA_W-1:0] CTRL1_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] CTRL2_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] BAUD_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RESET  = 8'h00;

  // Receive buffer depth
  localparam int          RX_DEPTH = 2;
  localparam logic [1:0]  RX_FULL_COUNT = 2'h2;

endpackage

// ==== tb/uart_status_flags_props.sv ====
// Port-level assertions for the status-flag block.
// Assumes one clock and a synchronous active-high reset; bound below.
`timescale 1ns/1ns

module uart_status_flags_props (
  input wire logic                              clock,
  input wire logic                              rst,
  input wire logic [uart_flags_pkg::ADDR_W-1:0] addr,
  input wire logic [uart_flags_pkg::DATA_W-1:0] wdata,
  input wire logic                              wr_stb,
  input wire logic                              rd_stb,
  input wire logic [uart_flags_pkg::DATA_W-1:0] rdata,
  input wire logic                              rx_word_done,
  input wire logic                              tx_shift_free,
  input wire logic                              tx_load,
  input wire logic [uart_flags_pkg::DATA_W-1:0] tx_word,
  input wire logic                              tx_pin,
  input wire logic                              receive_irq,
  input wire logic [uart_flags_pkg::DATA_W-1:0] control_one,
  input wire logic [uart_flags_pkg::DATA_W-1:0] control_two
);
  import uart_flags_pkg::*;
  logic       data_wr;
  logic [7:0] last_wr_r;
  assign data_wr = wr_stb && addr == OFS_DATA;
  // Last word software wrote, to judge what reaches the shifter
  always_ff @(posedge clock) begin
    if (rst) last_wr_r <= 8'h00;
    else if (data_wr) last_wr_r <= wdata;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_irq_cause: assert property (receive_irq |->
    $past(rx_word_done) && $past(control_two[C2_RX_IE]))
    else $error("receive irq without a loaded word");
  a_load_cause: assert property (tx_load |->
    $past(tx_shift_free) && $past(control_two[C2_TX_EN]) && !$past(data_wr))
    else $error("word moved to shifter without cause");
  a_load_word: assert property (tx_load |-> tx_word == last_wr_r)
    else $error("shifter word differs from written data");
  a_load_single: assert property (tx_load |=> !tx_load)
    else $error("shifter load longer than one cycle");
  a_off_status: assert property (rd_stb && addr == OFS_STATUS &&
    !control_one[C1_PORT_EN] && !$past(control_one[C1_PORT_EN])
    |=> rdata == STATUS_RESET) else $error("disabled port status wrong");
  a_off_enables: assert property (!control_one[C1_PORT_EN] && !wr_stb
    |=> control_two[7:6] == 2'b00 && !control_one[C1_SEND_BREAK])
    else $error("disabled port kept enables");
  a_off_line: assert property (!control_one[C1_PORT_EN] |=> tx_pin)
    else $error("serial line not high while disabled");
  a_ctrl_read: assert property (rd_stb && addr == OFS_CTRL1
    |=> rdata == ($past(control_one) & C1_READ_MASK))
    else $error("control one read back wrong");
  a_rdata_hold: assert property (!rd_stb |=> $stable(rdata))
    else $error("read data changed without a read");
  cover property (receive_irq);
  cover property (tx_load);
  cover property (rd_stb && addr == OFS_DATA && control_one[C1_PORT_EN]);
endmodule // uart_status_flags_props

bind uart_status_flags uart_status_flags_props i_props (
  .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .rx_word_done(rx_word_done),
  .tx_shift_free(tx_shift_free), .tx_load(tx_load), .tx_word(tx_word),
  .tx_pin(tx_pin), .receive_irq(receive_irq), .control_one(control_one),
  .control_two(control_two));

// ==== tb/far_end_model.sv ====
// Model of the serial engines beyond the block: one received word per
// request, and a ten-bit transmit shifter. Shares the block's clock.
`timescale 1ns/1ns

module far_end_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       send,
  input  wire logic       stall,
  input  wire logic [7:0] word,
  input  wire logic [2:0] errs,
  input  wire logic       tx_load,
  input  wire logic [7:0] tx_word,
  output logic            rx_start_seen,
  output logic            rx_stop_done,
  output logic            rx_word_done,
  output logic [7:0]      rx_word,
  output logic [2:0]      rx_err,
  output logic            tx_shift_free,
  output logic            tx_shift_busy,
  output logic            tx_serial
);
  logic [3:0] rx_cnt_r = 4'h0;
  logic [3:0] tx_cnt_r = 4'h0;
  logic [7:0] word_r = 8'h00;
  logic [2:0] err_r = 3'h0;
  logic [9:0] sh_r = 10'h3ff;
  always @(posedge clock) begin
    if (rst) begin
      rx_cnt_r <= 4'h0;
      tx_cnt_r <= 4'h0;
    end else begin
      if (send) begin
        rx_cnt_r <= 4'h5;
        word_r   <= word;
        err_r    <= errs;
      end else if (rx_cnt_r != 4'h0) begin
        rx_cnt_r <= rx_cnt_r - 4'h1;
      end
      if (tx_load) begin
        sh_r     <= {1'b1, tx_word, 1'b0};
        tx_cnt_r <= 4'ha;
      end else if (tx_cnt_r != 4'h0) begin
        sh_r     <= {1'b1, sh_r[9:1]};
        tx_cnt_r <= tx_cnt_r - 4'h1;
      end
    end
  end
  // Junk outside the done pulse, so stale values never pass
  assign rx_start_seen = send;
  assign rx_word_done  = rx_cnt_r == 4'h2;
  assign rx_stop_done  = rx_cnt_r == 4'h1;
  assign rx_word       = rx_word_done ? word_r : ~word_r;
  assign rx_err        = rx_word_done ? err_r : ~err_r;
  assign tx_shift_busy = tx_cnt_r != 4'h0;
  assign tx_shift_free = !tx_shift_busy && !stall;
  assign tx_serial     = sh_r[0];
endmodule // far_end_model

// ==== tb/tb_uart_status_flags.sv ====
// Self-checking bench for the status-flag block and its far-end model.
// Assumes the checker is bound to the block by its own file.
`timescale 1ns/1ns

module tb_uart_status_flags;
  import uart_flags_pkg::*;
  logic clock = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
  logic send = 1'b0, stall = 1'b1, rx_start_seen, rx_stop_done;
  logic rx_word_done, tx_shift_free, tx_shift_busy, tx_serial;
  logic tx_load, tx_pin, receive_irq;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00, word = 8'h00, rdata, rx_word, tx_word;
  logic [7:0] control_one, control_two, got, sent, irqs = 8'h00;
  logic [2:0] errs = 3'h0, rx_err;
  logic [7:0] baud;
  logic [31:0] r;
  int seed = 32'h787e, fail_count = 0, n_compared = 0, cycles = 0;

  uart_status_flags i_dut (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .rx_start_seen(rx_start_seen), .rx_stop_done(rx_stop_done),
    .rx_word_done(rx_word_done), .rx_word(rx_word), .rx_noise(rx_err[2]),
    .rx_framing_bad(rx_err[1]), .rx_parity_bad(rx_err[0]),
    .tx_shift_free(tx_shift_free), .tx_shift_busy(tx_shift_busy),
    .tx_serial(tx_serial), .tx_load(tx_load), .tx_word(tx_word),
    .tx_pin(tx_pin), .receive_irq(receive_irq), .control_one(control_one),
    .control_two(control_two), .baud_divisor(baud));
  far_end_model i_far (.clock(clock), .rst(rst), .send(send),
    .stall(stall), .word(word), .errs(errs), .tx_load(tx_load),
    .tx_word(tx_word), .rx_start_seen(rx_start_seen),
    .rx_stop_done(rx_stop_done), .rx_word_done(rx_word_done),
    .rx_word(rx_word), .rx_err(rx_err), .tx_shift_free(tx_shift_free),
    .tx_shift_busy(tx_shift_busy), .tx_serial(tx_serial));

  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (receive_irq === 1'b1) irqs <= irqs + 8'h01;
    if (tx_load === 1'b1) sent <= tx_word;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  // Status byte from error nibble {parity,noise,framing,overrun} and idle, full and empty flags
  function automatic logic [7:0] st(input logic [3:0] e,
                                    input logic ri, rf, ti, te);
    st = {e, ri, rf, ti, te};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  task automatic rdv(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    logic [7:0] d;
    rdv(a, d);
    chk(d, e);
  endtask
  task automatic rxs(input logic [7:0] w, input logic [2:0] e);
    @(posedge clock);
    send <= 1'b1;
    word <= w;
    errs <= e;
    @(posedge clock);
    send <= 1'b0;
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(OFS_STATUS, STATUS_RESET);
    wr(OFS_STATUS, 8'hf4);
    rd(OFS_STATUS, STATUS_RESET);
    rd(3'h5, 8'h00);
    wr(OFS_CTRL1, 8'h80);
    wr(OFS_CTRL2, 8'h44);
    rd(OFS_STATUS, st(4'h0, 1, 0, 1, 1));
    wr(OFS_DATA, 8'h5a);
    rd(OFS_STATUS, st(4'h0, 1, 0, 0, 0));
    wr(OFS_CTRL2, 8'hc4);
    rd(OFS_STATUS, st(4'h0, 1, 0, 0, 1));
    stall <= 1'b0;
    repeat (16) @(posedge clock);
    chk(sent, 8'h5a);
    rd(OFS_STATUS, st(4'h0, 1, 0, 1, 1));
    chk({7'h00, tx_pin}, 8'h01);
    // Record dropped by a data read, so the write must not clear
    rdv(OFS_DATA, got);
    stall <= 1'b1;
    wr(OFS_DATA, 8'hc3);
    rdv(OFS_STATUS, got);
    chk(got & 8'h01, 8'h01);
    stall <= 1'b0;
    repeat (16) @(posedge clock);
    rxs(8'h3c, 3'h7);
    rd(OFS_STATUS, st(4'h0, 0, 0, 1, 1));
    repeat (6) @(posedge clock);
    rd(OFS_STATUS, st(4'b0110, 1, 1, 1, 1));
    rd(OFS_DATA, 8'h3c);
    rd(OFS_STATUS, st(4'h0, 1, 0, 1, 1));
    wr(OFS_CTRL1, 8'ha0);
    rxs(8'h11, 3'h1);
    repeat (8) @(posedge clock);
    rxs(8'h22, 3'h0);
    repeat (8) @(posedge clock);
    rxs(8'h33, 3'h4);
    repeat (8) @(posedge clock);
    rd(OFS_STATUS, st(4'b1001, 1, 1, 1, 1));
    rd(OFS_DATA, 8'h11);
    rd(OFS_STATUS, st(4'h0, 1, 1, 1, 1));
    rd(OFS_DATA, 8'h22);
    rd(OFS_STATUS, st(4'h0, 1, 0, 1, 1));
    chk(irqs, 8'h03);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      rxs(r[7:0], r[10:8]);
      repeat (8) @(posedge clock);
      rd(OFS_STATUS, st({r[8], r[10], r[9], 1'b0}, 1, 1, 1, 1));
      rd(OFS_DATA, r[7:0]);
    end
    // Break with nothing queued: idle must drop and the line go low
    wr(OFS_CTRL1, 8'ha4);
    rd(OFS_STATUS, st(4'h0, 1, 0, 0, 1));
    chk({7'h00, tx_pin}, 8'h00);
    wr(OFS_CTRL1, 8'ha0);
    r = $random(seed);
    wr(OFS_BAUD, r[7:0]);
    rd(OFS_BAUD, r[7:0]);
    chk(baud, r[7:0]);
    rxs(8'h66, 3'h2);
    repeat (8) @(posedge clock);
    wr(OFS_CTRL1, 8'h00);
    rd(OFS_STATUS, STATUS_RESET);
    rd(OFS_CTRL2, 8'h04);
    wr(OFS_CTRL1, 8'h7b);
    rd(OFS_CTRL1, 8'h78);
    test_done();
  end
endmodule // tb_uart_status_flags
